// [verilog/bstap_top.sv]
// Boundary-scan test access port with word hand-off into the system clock domain.

module bstap_top (
    input  wire logic                             i_clock,
    input  wire logic                             i_rst_n,
    input  wire logic                             i_tck,
    input  wire logic                             i_tms,
    input  wire logic                             i_tdi,
    output logic                                  o_tdo,
    output logic                                  o_tdo_oe,
    input  wire logic [bstap_pkg::BSTAP_NF_W-1:0] i_nf_in,
    output logic      [bstap_pkg::BSTAP_NF_W-1:0] o_nf_out,
    output logic      [bstap_pkg::BSTAP_DR_W-1:0] o_dr_update,
    output logic      [bstap_pkg::BSTAP_WORD_W-1:0] o_instr,
    output logic                                  o_instr_valid,
    input  wire logic                             i_instr_ready
);
    import bstap_pkg::*;

    // Reset release is resynchronised to the test clock; assertion stays asynchronous.
    logic                   rst_tck_s1_r;
    logic                   rst_tck_s1_nxt;
    logic                   rst_tck_n_r;
    logic                   rst_tck_n_nxt;
    bstap_state_t           state;

    // Rising-edge test-clock state.
    logic [BSTAP_IR_W-1:0]  ir_sh_r;
    logic [BSTAP_IR_W-1:0]  ir_sh_nxt;
    logic [BSTAP_DR_W-1:0]  dr_sh_r;
    logic [BSTAP_DR_W-1:0]  dr_sh_nxt;
    logic                   byp_r;
    logic                   byp_nxt;
    logic [BSTAP_NF_W-1:0]  nf_cap_r;
    logic [BSTAP_NF_W-1:0]  nf_cap_nxt;
    logic [BSTAP_WORD_W-1:0] word_r;
    logic [BSTAP_WORD_W-1:0] word_nxt;
    logic                   req_r;
    logic                   req_nxt;
    logic                   ack_s1_r;
    logic                   ack_s1_nxt;
    logic                   ack_s2_r;
    logic                   ack_s2_nxt;

    // Falling-edge test-clock state.
    logic                   tdo_r;
    logic                   tdo_nxt;
    logic                   tdo_oe_r;
    logic                   tdo_oe_nxt;
    logic [BSTAP_IR_W-1:0]  ir_act_r;
    logic [BSTAP_IR_W-1:0]  ir_act_nxt;
    logic [BSTAP_DR_W-1:0]  dr_upd_r;
    logic [BSTAP_DR_W-1:0]  dr_upd_nxt;
    logic [BSTAP_NF_W-1:0]  nf_out_r;
    logic [BSTAP_NF_W-1:0]  nf_out_nxt;

    // System-clock state; bypass_sel is decoded from the falling-edge ir_act_r.
    logic                   req_s1_r;
    logic                   req_s1_nxt;
    logic                   req_s2_r;
    logic                   req_s2_nxt;
    logic                   seen_r;
    logic                   seen_nxt;
    logic [BSTAP_WORD_W-1:0] out_r;
    logic [BSTAP_WORD_W-1:0] out_nxt;
    logic                   out_vld_r;
    logic                   out_vld_nxt;
    logic                   pending;
    logic                   bypass_sel;

    bstap_fifo_if fifo_bus ();

    // Release reaches the test-clock logic only after two rising edges, so a
    // reset lifted close to an edge cannot leave half of the port running.
    always_comb begin
        rst_tck_s1_nxt = 1'b1;
        rst_tck_n_nxt  = rst_tck_s1_r;
    end

    always_ff @(posedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_tck_s1_r <= 1'b0;
            rst_tck_n_r  <= 1'b0;
        end else begin
            rst_tck_s1_r <= rst_tck_s1_nxt;
            rst_tck_n_r  <= rst_tck_n_nxt;
        end
    end

    bstap_fsm u_fsm (
        .i_tck   (i_tck),
        .i_rst_n (rst_tck_n_r),
        .i_tms   (i_tms),
        .o_state (state)
    );

    assign bypass_sel = bstap_is_bypass(ir_act_r);

    // Both scan chains move towards bit zero, so the newest bit enters at the top.
    function automatic logic [BSTAP_IR_W-1:0] shift_in(
        input logic [BSTAP_IR_W-1:0] cur,
        input logic                  bit_in
    );
        return {bit_in, cur[BSTAP_IR_W-1:1]};
    endfunction

    always_comb begin
        ir_sh_nxt  = ir_sh_r;
        dr_sh_nxt  = dr_sh_r;
        byp_nxt    = byp_r;
        word_nxt   = word_r;
        req_nxt    = req_r;
        nf_cap_nxt = i_nf_in;
        case (state)
            TAP_CAPTURE_IR: begin
                ir_sh_nxt = BSTAP_IR_CAPTURE;
            end
            TAP_SHIFT_IR: begin
                ir_sh_nxt = shift_in(ir_sh_r, i_tdi);
            end
            TAP_CAPTURE_DR: begin
                if (bypass_sel) begin
                    byp_nxt = 1'b0;
                end else begin
                    // Any other instruction reads the normal inputs back through the chain.
                    dr_sh_nxt = i_nf_in;
                end
            end
            TAP_SHIFT_DR: begin
                if (bypass_sel) begin
                    byp_nxt = i_tdi;
                end else begin
                    dr_sh_nxt = shift_in(dr_sh_r, i_tdi);
                end
            end
            TAP_UPDATE_IR: begin
                // A word still unacknowledged is kept; the newer one is dropped.
                if (req_r == ack_s2_r) begin
                    word_nxt = ir_sh_r;
                    req_nxt  = ~req_r;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge i_tck or negedge rst_tck_n_r) begin
        if (!rst_tck_n_r) begin
            ir_sh_r  <= BSTAP_IR_RESET;
            dr_sh_r  <= BSTAP_DR_RESET;
            byp_r    <= 1'b0;
            nf_cap_r <= BSTAP_NF_RESET;
            word_r   <= BSTAP_IR_RESET;
            req_r    <= 1'b0;
        end else begin
            ir_sh_r  <= ir_sh_nxt;
            dr_sh_r  <= dr_sh_nxt;
            byp_r    <= byp_nxt;
            nf_cap_r <= nf_cap_nxt;
            word_r   <= word_nxt;
            req_r    <= req_nxt;
        end
    end

    // The echo is a level toggle, so two stages suffice and no pulse can be lost.
    always_comb begin
        ack_s1_nxt = seen_r;
        ack_s2_nxt = ack_s1_r;
    end

    always_ff @(posedge i_tck or negedge rst_tck_n_r) begin
        if (!rst_tck_n_r) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            ack_s1_r <= ack_s1_nxt;
            ack_s2_r <= ack_s2_nxt;
        end
    end

    always_comb begin
        tdo_oe_nxt = bstap_is_shift(state);
        // Outside shifting TDO keeps its last bit; only the enable marks it invalid.
        tdo_nxt    = tdo_r;
        if (state == TAP_SHIFT_IR) begin
            tdo_nxt = ir_sh_r[0];
        end else if (state == TAP_SHIFT_DR) begin
            tdo_nxt = bypass_sel ? byp_r : dr_sh_r[0];
        end
        // The transceiver path never looks at the instruction.
        nf_out_nxt = nf_cap_r;
        ir_act_nxt = ir_act_r;
        dr_upd_nxt = dr_upd_r;
        case (state)
            TAP_RESET:     ir_act_nxt = BSTAP_IR_RESET;
            TAP_UPDATE_IR: ir_act_nxt = ir_sh_r;
            TAP_UPDATE_DR: begin
                if (!bypass_sel) begin
                    dr_upd_nxt = dr_sh_r;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(negedge i_tck or negedge rst_tck_n_r) begin
        if (!rst_tck_n_r) begin
            tdo_r    <= 1'b0;
            tdo_oe_r <= 1'b0;
            ir_act_r <= BSTAP_IR_RESET;
            dr_upd_r <= BSTAP_DR_RESET;
            nf_out_r <= BSTAP_NF_RESET;
        end else begin
            tdo_r    <= tdo_nxt;
            tdo_oe_r <= tdo_oe_nxt;
            ir_act_r <= ir_act_nxt;
            dr_upd_r <= dr_upd_nxt;
            nf_out_r <= nf_out_nxt;
        end
    end

    // Toggle handshake: word_r is held still until the system side echoes the toggle.
    always_comb begin
        req_s1_nxt = req_r;
        req_s2_nxt = req_s1_r;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
        end else begin
            req_s1_r <= req_s1_nxt;
            req_s2_r <= req_s2_nxt;
        end
    end

    assign pending           = req_s2_r != seen_r;
    assign fifo_bus.in_valid = pending;
    assign fifo_bus.in_data  = word_r;
    assign fifo_bus.out_ready = !out_vld_r || i_instr_ready;

    always_comb begin
        // A full FIFO holds the echo back, which in turn drops later hand-offs.
        seen_nxt    = (pending && fifo_bus.in_ready) ? req_s2_r : seen_r;
        out_nxt     = out_r;
        out_vld_nxt = out_vld_r;
        if (fifo_bus.out_ready) begin
            out_vld_nxt = fifo_bus.out_valid;
            if (fifo_bus.out_valid) begin
                out_nxt = fifo_bus.out_data;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seen_r    <= 1'b0;
            out_r     <= BSTAP_IR_RESET;
            out_vld_r <= 1'b0;
        end else begin
            seen_r    <= seen_nxt;
            out_r     <= out_nxt;
            out_vld_r <= out_vld_nxt;
        end
    end

    bstap_fifo #(
        .WIDTH (BSTAP_WORD_W),
        .DEPTH (BSTAP_FIFO_DEPTH)
    ) u_fifo (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .f       (fifo_bus.fifo)
    );

    assign o_tdo         = tdo_r;
    assign o_tdo_oe      = tdo_oe_r;
    assign o_nf_out      = nf_out_r;
    assign o_dr_update   = dr_upd_r;
    assign o_instr       = out_r;
    assign o_instr_valid = out_vld_r;
endmodule

// [shared/bstap_pkg.sv]
// Constants, state type and decode helpers shared by the boundary-scan port design.
package bstap_pkg;

    localparam int unsigned BSTAP_IR_W       = 8;
    localparam int unsigned BSTAP_DR_W       = 8;
    localparam int unsigned BSTAP_NF_W       = 8;
    localparam int unsigned BSTAP_WORD_W     = 8;
    localparam int unsigned BSTAP_FIFO_DEPTH = 16;

    localparam logic [7:0] BSTAP_IR_CAPTURE = 8'h81;
    localparam logic [7:0] BSTAP_IR_BYPASS  = 8'hff;
    localparam logic [7:0] BSTAP_IR_RESET   = 8'hff;
    localparam logic [7:0] BSTAP_DR_RESET   = 8'h00;
    localparam logic [7:0] BSTAP_NF_RESET   = 8'h00;

    typedef enum logic [3:0] {
        TAP_RESET,
        TAP_IDLE,
        TAP_SEL_DR,
        TAP_CAPTURE_DR,
        TAP_SHIFT_DR,
        TAP_EXIT1_DR,
        TAP_PAUSE_DR,
        TAP_EXIT2_DR,
        TAP_UPDATE_DR,
        TAP_SEL_IR,
        TAP_CAPTURE_IR,
        TAP_SHIFT_IR,
        TAP_EXIT1_IR,
        TAP_PAUSE_IR,
        TAP_EXIT2_IR,
        TAP_UPDATE_IR
    } bstap_state_t;

    // An all-ones code selects the one-bit bypass path.
    function automatic logic bstap_is_bypass(input logic [7:0] instr);
        return instr == BSTAP_IR_BYPASS;
    endfunction

    function automatic logic bstap_is_shift(input bstap_state_t st);
        return (st == TAP_SHIFT_IR) || (st == TAP_SHIFT_DR);
    endfunction

endpackage

// [shared/bstap_fifo_if.sv]
// Valid/ready stream carrier between the port top and its word FIFO.
interface bstap_fifo_if;
    import bstap_pkg::*;

    logic [BSTAP_WORD_W-1:0] in_data;
    logic                    in_valid;
    logic                    in_ready;
    logic [BSTAP_WORD_W-1:0] out_data;
    logic                    out_valid;
    logic                    out_ready;

    modport fifo (
        input  in_data,
        input  in_valid,
        output in_ready,
        output out_data,
        output out_valid,
        input  out_ready
    );

    modport user (
        output in_data,
        output in_valid,
        input  in_ready,
        input  out_data,
        input  out_valid,
        output out_ready
    );
endinterface

// [verilog/bstap_fifo.sv]
// Synchronous word FIFO with valid/ready on both sides.
module bstap_fifo #(
    parameter int unsigned WIDTH = bstap_pkg::BSTAP_WORD_W,
    parameter int unsigned DEPTH = bstap_pkg::BSTAP_FIFO_DEPTH
) (
    input  wire logic   i_clock,
    input  wire logic   i_rst_n,
    bstap_fifo_if.fifo  f
);
    import bstap_pkg::*;

    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      wr_ptr_nxt;
    logic [AW:0]      rd_ptr_r;
    logic [AW:0]      rd_ptr_nxt;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    // Pointers carry one extra bit so that full and empty are told apart.
    assign empty      = wr_ptr_r == rd_ptr_r;
    assign full       = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign f.in_ready  = !full;
    assign f.out_valid = !empty;
    assign f.out_data  = mem[rd_ptr_r[AW-1:0]];
    assign push       = f.in_valid && !full;
    assign pop        = f.out_ready && !empty;

    always_comb begin
        wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
        rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
        end
    end

    // Storage carries no reset so it maps onto plain memory.
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= f.in_data;
        end
    end
endmodule

// [verilog/bstap_fsm.sv]
// Sixteen-state test access port controller advanced on the rising test clock.
module bstap_fsm (
    input  wire logic              i_tck,
    input  wire logic              i_rst_n,
    input  wire logic              i_tms,
    output bstap_pkg::bstap_state_t o_state
);
    import bstap_pkg::*;

    bstap_state_t state_r;
    bstap_state_t state_nxt;

    always_comb begin
        case (state_r)
            TAP_RESET:      state_nxt = i_tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE:       state_nxt = i_tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR:     state_nxt = i_tms ? TAP_SEL_IR : TAP_CAPTURE_DR;
            TAP_CAPTURE_DR: state_nxt = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR:   state_nxt = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR:   state_nxt = i_tms ? TAP_UPDATE_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR:   state_nxt = i_tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR:   state_nxt = i_tms ? TAP_UPDATE_DR : TAP_SHIFT_DR;
            TAP_UPDATE_DR:  state_nxt = i_tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR:     state_nxt = i_tms ? TAP_RESET : TAP_CAPTURE_IR;
            TAP_CAPTURE_IR: state_nxt = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR:   state_nxt = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR:   state_nxt = i_tms ? TAP_UPDATE_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR:   state_nxt = i_tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR:   state_nxt = i_tms ? TAP_UPDATE_IR : TAP_SHIFT_IR;
            TAP_UPDATE_IR:  state_nxt = i_tms ? TAP_SEL_DR : TAP_IDLE;
            default:        state_nxt = TAP_RESET;
        endcase
    end

    // Mode select is sampled directly by the rising test clock.
    always_ff @(posedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= TAP_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_state = state_r;
endmodule

// [testbench/bstap_checker.sv]
// Concurrent checks on the scan port pins and on the instruction hand-off.
module bstap_checker (
    input wire logic                               i_clock,
    input wire logic                               i_rst_n,
    input wire logic                               i_tck,
    input wire logic                               i_tms,
    input wire logic                               i_tdi,
    input wire logic                               o_tdo,
    input wire logic                               o_tdo_oe,
    input wire logic [bstap_pkg::BSTAP_NF_W-1:0]   i_nf_in,
    input wire logic [bstap_pkg::BSTAP_NF_W-1:0]   o_nf_out,
    input wire logic [bstap_pkg::BSTAP_DR_W-1:0]   o_dr_update,
    input wire logic [bstap_pkg::BSTAP_WORD_W-1:0] o_instr,
    input wire logic                               o_instr_valid,
    input wire logic                               i_instr_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    import bstap_pkg::*;
    logic [2:0]   edges_r;
    bstap_state_t st_r;
    bstap_state_t st_nxt;
    logic [7:0]   ir_r;
    logic [7:0]   upd_r;

    // Shadow controller; it waits out the same two resync edges as the port.
    always_comb begin
        case (st_r)
            TAP_RESET:      st_nxt = i_tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE:       st_nxt = i_tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR:     st_nxt = i_tms ? TAP_SEL_IR : TAP_CAPTURE_DR;
            TAP_CAPTURE_DR: st_nxt = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR:   st_nxt = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR:   st_nxt = i_tms ? TAP_UPDATE_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR:   st_nxt = i_tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR:   st_nxt = i_tms ? TAP_UPDATE_DR : TAP_SHIFT_DR;
            TAP_SEL_IR:     st_nxt = i_tms ? TAP_RESET : TAP_CAPTURE_IR;
            TAP_CAPTURE_IR: st_nxt = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR:   st_nxt = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR:   st_nxt = i_tms ? TAP_UPDATE_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR:   st_nxt = i_tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR:   st_nxt = i_tms ? TAP_UPDATE_IR : TAP_SHIFT_IR;
            default:        st_nxt = i_tms ? TAP_SEL_DR : TAP_IDLE;
        endcase
    end

    always_ff @(posedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            edges_r <= 3'h0;
            st_r <= TAP_RESET;
            ir_r <= 8'h00;
            upd_r <= 8'hff;
        end else begin
            edges_r <= (edges_r == 3'h7) ? edges_r : edges_r + 3'h1;
            st_r <= (edges_r >= 3'h2) ? st_nxt : st_r;
            ir_r <= (st_r == TAP_CAPTURE_IR) ? 8'h81 :
                    (st_r == TAP_SHIFT_IR) ? {i_tdi, ir_r[7:1]} : ir_r;
            upd_r <= (st_r == TAP_UPDATE_IR) ? ir_r : upd_r;
        end
    end

    a_tdo_fall_only: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_tck && $past(i_tck) |-> $stable(o_tdo) && $stable(o_tdo_oe) && $stable(o_nf_out))
        else $error("An output moved while the test clock was high.");
    a_nf_follow: assert property (@(posedge i_tck) disable iff (!i_rst_n)
        edges_r >= 3'h4 |-> o_nf_out == $past(i_nf_in))
        else $error("Normal output differs from the input taken one edge before.");
    a_oe_in_shift: assert property (@(posedge i_tck) disable iff (!i_rst_n)
        edges_r >= 3'h3 |-> o_tdo_oe == (st_r == TAP_SHIFT_IR || st_r == TAP_SHIFT_DR))
        else $error("Serial output enable does not match the shift states.");
    a_oe_exit_off: assert property (@(posedge i_tck) disable iff (!i_rst_n)
        ($past(st_r) == TAP_SHIFT_IR && st_r == TAP_EXIT1_IR) ||
        ($past(st_r) == TAP_SHIFT_DR && st_r == TAP_EXIT1_DR) |-> $fell(o_tdo_oe))
        else $error("Serial output not released on entering exit.");
    a_ir_serial_out: assert property (@(posedge i_tck) disable iff (!i_rst_n)
        st_r == TAP_SHIFT_IR |-> o_tdo == ir_r[0])
        else $error("Instruction shift output bit is wrong.");
    a_instr_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_instr_valid && !i_instr_ready |=> o_instr_valid && $stable(o_instr))
        else $error("Instruction word dropped before it was accepted.");
    a_instr_word: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $rose(o_instr_valid) |-> o_instr == upd_r)
        else $error("Handed-off instruction differs from the word shifted in.");
    a_dr_update_when: assert property (@(posedge i_tck) disable iff (!i_rst_n)
        !$stable(o_dr_update) |-> st_r == TAP_UPDATE_DR)
        else $error("Data parallel stage changed outside update.");

    c_handoff: cover property (@(posedge i_clock) $rose(o_instr_valid));
    c_dr_update: cover property (@(posedge i_tck) st_r == TAP_UPDATE_DR);
    c_ir_last: cover property (@(posedge i_tck) st_r == TAP_SHIFT_IR && i_tms);
endmodule

bind bstap_top bstap_checker i_bstap_checker (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_tck(i_tck), .i_tms(i_tms), .i_tdi(i_tdi),
    .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_nf_in(i_nf_in), .o_nf_out(o_nf_out),
    .o_dr_update(o_dr_update), .o_instr(o_instr), .o_instr_valid(o_instr_valid),
    .i_instr_ready(i_instr_ready)
);

// [testbench/bstap_ctrl_model.sv]
// Behavioural scan controller that clocks the port one state per call.
module bstap_ctrl_model (
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    input  wire logic i_tdo
);
    timeunit 1ns;
    timeprecision 1ps;

    // The test clock stands low between calls, so it only runs inside frames.
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
    end

    task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
        o_tms = tms_v;
        o_tdi = tdi_v;
        #40 o_tck = 1'b1;
        tdo_v = i_tdo;
        #40 o_tck = 1'b0;
    endtask
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the scan port and its instruction hand-off.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bstap_pkg::*;
    logic       i_clock;
    logic       i_rst_n;
    logic       tck;
    logic       tms;
    logic       tdi;
    logic       o_tdo;
    logic       o_tdo_oe;
    logic [7:0] i_nf_in;
    logic [7:0] o_nf_out;
    logic [7:0] o_dr_update;
    logic [7:0] o_instr;
    logic       o_instr_valid;
    logic       i_instr_ready;
    wire logic  tdo_pin;
    int         mismatches = 0;
    int         n_checks = 0;

    // The serial output floats when not enabled, so a stale bit cannot pass.
    assign tdo_pin = o_tdo_oe ? o_tdo : 1'bz;

    bstap_top i_bstap_top (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_nf_in(i_nf_in), .o_nf_out(o_nf_out),
        .o_dr_update(o_dr_update), .o_instr(o_instr), .o_instr_valid(o_instr_valid),
        .i_instr_ready(i_instr_ready)
    );

    bstap_ctrl_model i_bstap_ctrl_model (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo_pin));

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    task automatic close_out();
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Steps the controller with the given mode bits, first bit first.
    task automatic moves(input logic [7:0] seq, input int n);
        logic d;
        for (int i = 0; i < n; i++) begin
            i_bstap_ctrl_model.step(seq[i], 1'b0, d);
        end
    endtask

    // Shifts n bits from a shift state, then steps through exit into update.
    task automatic shift(input logic [7:0] din, input logic [7:0] exp, input int n);
        logic d;
        for (int i = 0; i < n; i++) begin
            i_bstap_ctrl_model.step(i == n - 1, din[i], d);
            check("tdo bit", {7'h00, d}, {7'h00, exp[i]});
        end
        i_bstap_ctrl_model.step(1'b1, 1'b0, d);
        check("tdo released", {7'h00, d}, {7'h00, 1'bz});
        #1;
    endtask

    task automatic t_handoff(input logic [7:0] exp);
        int k;
        k = 0;
        do begin
            @(posedge i_clock);
            #1;
            k++;
        end while (o_instr_valid !== 1'b1 && k < 100);
        if (o_instr_valid !== 1'b1) begin
            mismatches++;
            close_out();
        end else begin
            check("instr word", o_instr, exp);
            i_instr_ready = 1'b1;
            @(posedge i_clock);
            #1;
            i_instr_ready = 1'b0;
            check("instr valid after accept", {7'h00, o_instr_valid}, 8'h00);
        end
    endtask

    task automatic t_reset();
        check("reset instr", o_instr, 8'hff);
        check("reset valid", {7'h00, o_instr_valid}, 8'h00);
        check("reset tdo", {7'h00, tdo_pin}, {7'h00, 1'bz});
        check("reset update", o_dr_update, 8'h00);
    endtask

    task automatic t_bypass_scan();
        moves(8'h06, 5);
        shift(8'hff, 8'h81, 8);
        moves(8'h01, 3);
        t_handoff(8'hff);
        shift(8'h05, 8'h02, 3);
        check("update under bypass", o_dr_update, 8'h00);
        moves(8'h07, 3);
    endtask

    task automatic t_data_scan();
        i_nf_in = 8'ha5;
        moves(8'h06, 5);
        shift(8'h3c, 8'h81, 8);
        moves(8'h01, 3);
        t_handoff(8'h3c);
        shift(8'h5a, 8'ha5, 8);
        check("parallel update", o_dr_update, 8'h5a);
        check("normal path", o_nf_out, 8'ha5);
        moves(8'h07, 3);
        moves(8'h02, 4);
        shift(8'h05, 8'h02, 3);
        moves(8'h07, 3);
    endtask

    initial begin
        i_rst_n = 1'b0;
        i_nf_in = 8'h00;
        i_instr_ready = 1'b0;
        repeat (4) @(posedge i_clock);
        #1;
        t_reset();
        i_rst_n = 1'b1;
        moves(8'hff, 3);
        t_bypass_scan();
        t_data_scan();
        close_out();
    end
endmodule
